/* File: shared/wsc_cfg.svh */
// constants of the waveform sequencer: register offsets, field positions, reset values
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH

`define WSC_ADDR_W 8
`define WSC_REG_CTRL 8'h00
`define WSC_REG_START 8'h04
`define WSC_REG_SEQLOOP 8'h08
`define WSC_REG_STATUS 8'h0c
`define WSC_REG_TADDR 8'h10
`define WSC_REG_TSEGSTART 8'h14
`define WSC_REG_TSEGLEN 8'h18
`define WSC_REG_TLOOP 8'h1c
`define WSC_REG_TFLAGS 8'h20
`define WSC_REG_TWRITE 8'h24
`define WSC_REG_POS 8'h28
`define WSC_CTRL_RUN 0
`define WSC_CTRL_ARMED 1
`define WSC_CTRL_TMODE_LO 2
`define WSC_CTRL_SEQADV_LO 4
`define WSC_FLAG_ADV_LO 0
`define WSC_FLAG_LOOPEND 2
`define WSC_FLAG_LOOPBEG 3
`define WSC_FLAG_SEQEND 4
`define WSC_CTRL_RESET 32'h0000_0000

`endif

/* File: shared/wsc_pkg.sv */
// types of the waveform sequencer
package wsc_pkg;
	typedef enum logic [1:0] {
		WSC_TRIG_CONT = 2'b00,
		WSC_TRIG_TRIG = 2'b01,
		WSC_TRIG_GATE = 2'b10
	} wsc_trig_t;
	typedef enum logic [1:0] {
		WSC_ADV_AUTO = 2'b00,
		WSC_ADV_COND = 2'b01,
		WSC_ADV_REPEAT = 2'b10,
		WSC_ADV_SINGLE = 2'b11
	} wsc_adv_t;
	typedef enum logic [2:0] {
		WSC_ST_IDLE = 3'b000,
		WSC_ST_WAIT = 3'b001,
		WSC_ST_PLAY = 3'b010,
		WSC_ST_HOLD = 3'b011,
		WSC_ST_DONE = 3'b100
	} wsc_state_t;
endpackage : wsc_pkg

/* File: hdl/wsc_event_latch.sv */
// sticky advancement event store: set wins over consume, clear wins over set
module wsc_event_latch (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// event in, consume, clear
	input wire logic eventIn,
	input wire logic consume,
	input wire logic flush,
	// stored flag
	output logic pending
);
	typedef struct packed {
		logic prevIn;
		logic flag;
	} wsc_evl_t;
	wsc_evl_t s, next_s;

	always_comb begin
		next_s = s;
		next_s.prevIn = eventIn;
		if (consume || flush) begin
			next_s.flag = 1'b0; // [RULE21]
		end
		if (eventIn && !s.prevIn && !flush) begin
			next_s.flag = 1'b1; // [RULE21]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0; // [RULE23]
		end else begin
			s <= next_s;
		end
	end

	assign pending = s.flag;
endmodule : wsc_event_latch

/* File: hdl/wsc_edge_detect.sv */
// rising and falling edge detector for a synchronous level
module wsc_edge_detect (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// level in
	input wire logic level,
	// edges out
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic prev;
	} wsc_edg_t;
	wsc_edg_t s, next_s;

	always_comb begin
		next_s.prev = level;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rise = level && !s.prev;
	assign fall = !level && s.prev;
endmodule : wsc_edge_detect

/* File: hdl/wsc_sequencer.sv */
// sequencer engine: walks the sequence table and drives sample memory addresses
//
// Chosen here: the address-and-strobe port and the address map.
`include "wsc_cfg.svh"

// Functional notes
// [RULE1] table entries hold segment, loops, advancement
// [RULE2] start at start pointer, then next entry
// [RULE3] loop end jumps back while count remains
// [RULE4] entries may share sample memory regions
// [RULE5] one granule address per sync clock
// [RULE6] segment lengths multiple of granularity, minimum
// [RULE7] sequence repeats endlessly or counted
// [RULE8] continuous mode starts at run, endless
// [RULE9] triggered plays count, stops, re-arms
// [RULE10] triggers during play are dropped
// [RULE11] gate rise starts, gate fall stops
// [RULE12] gated mode requires continuous top advancement; here seqAdv is only stored and read back, never checked
// [RULE13] self armed obeys trigger mode only
// [RULE14] armed continuous loops first element until enable
// [RULE15] otherwise armed adds enable start condition
// [RULE16] each entry carries its own advancement mode
// [RULE17] auto advances after all loops
// [RULE18] conditional repeats until event, finishes pass
// [RULE19] repeated plays loops then holds for event
// [RULE20] single plays one pass per event
// [RULE21] advancement event latched until consumed
// [RULE22] loop counts one to 32-bit maximum
// [RULE23] reset or program mode leaves sequencer idle
module wsc_sequencer #(
	parameter int DEPTH_W = 6,
	parameter int MEM_AW = 24,
	parameter int GRAN_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [`WSC_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	// start and advancement sources
	input wire logic trigIn,
	input wire logic enableIn,
	input wire logic eventIn,
	// sample memory side
	output logic [MEM_AW-1:0] memAddr,
	output logic memValid,
	output logic holdLast
);
	import wsc_pkg::*;

	localparam int DEPTH = 1 << DEPTH_W;

	////////////////////////////////////////////////////////////////////////////
	// sequence table
	logic [MEM_AW-1:0] tabStart [DEPTH]; // [RULE1] [RULE4]
	logic [GRAN_W-1:0] tabLen [DEPTH];
	logic [31:0] tabLoop [DEPTH];
	logic [4:0] tabFlags [DEPTH]; // [RULE16]

	typedef struct packed {
		wsc_state_t state;
		logic run;
		logic armed;
		wsc_trig_t trigMode;
		wsc_adv_t seqAdv;
		logic [DEPTH_W-1:0] startPtr;
		logic [31:0] seqLoopCfg;
		logic [DEPTH_W-1:0] tAddr;
		logic [MEM_AW-1:0] tSegStart;
		logic [GRAN_W-1:0] tSegLen;
		logic [31:0] tLoop;
		logic [4:0] tFlags;
		logic [DEPTH_W-1:0] idx;
		logic [DEPTH_W-1:0] loopBeg;
		logic [31:0] blockLoops;
		logic [GRAN_W-1:0] gran;
		logic [31:0] segLoops;
		logic [31:0] seqLoops;
		logic firstHold;
		logic enSeen;
		logic rdPend;
		logic [31:0] rdData;
		logic [MEM_AW-1:0] addrOut;
		logic validOut;
		logic holdOut;
	} wsc_state_s_t;
	wsc_state_s_t s, next_s;

	logic trigRise, trigFall, enRise, evPending, consume, flush;

	wsc_edge_detect u_trig (
		.clk(clk),
		.reset(reset),
		.level(trigIn),
		.rise(trigRise),
		.fall(trigFall)
	);

	wsc_edge_detect u_en (
		.clk(clk),
		.reset(reset),
		.level(enableIn),
		.rise(enRise),
		.fall()
	);

	wsc_event_latch u_evt (
		.clk(clk),
		.reset(reset),
		.eventIn(eventIn),
		.consume(consume),
		.flush(flush),
		.pending(evPending)
	);

	function automatic wsc_adv_t advOf(input logic [4:0] f);
		return wsc_adv_t'(f[`WSC_FLAG_ADV_LO +: 2]);
	endfunction : advOf

	////////////////////////////////////////////////////////////////////////////
	// control
	logic [4:0] curFlags;
	logic segEnd, passEnd, allLoops, startOk, canStart;
	wsc_adv_t curAdv;

	always_comb begin
		next_s = s;
		consume = 1'b0;
		flush = !s.run; // [RULE23]
		curFlags = tabFlags[s.idx];
		curAdv = advOf(curFlags);
		segEnd = (s.gran == tabLen[s.idx] - GRAN_W'(1));
		allLoops = (s.segLoops >= tabLoop[s.idx]);
		passEnd = 1'b0;
		canStart = 1'b0;
		next_s.rdPend = regRead;
		next_s.validOut = 1'b0;
		next_s.holdOut = 1'b0;
		if (regWrite) begin
			unique case (regAddr)
				`WSC_REG_CTRL: begin
					next_s.run = regWrData[`WSC_CTRL_RUN];
					next_s.armed = regWrData[`WSC_CTRL_ARMED];
					next_s.trigMode = wsc_trig_t'(regWrData[`WSC_CTRL_TMODE_LO +: 2]);
					next_s.seqAdv = wsc_adv_t'(regWrData[`WSC_CTRL_SEQADV_LO +: 2]);
				end
				`WSC_REG_START: next_s.startPtr = regWrData[DEPTH_W-1:0]; // [RULE2]
				`WSC_REG_SEQLOOP: next_s.seqLoopCfg = regWrData; // [RULE7]
				`WSC_REG_TADDR: next_s.tAddr = regWrData[DEPTH_W-1:0];
				`WSC_REG_TSEGSTART: next_s.tSegStart = regWrData[MEM_AW-1:0];
				`WSC_REG_TSEGLEN: next_s.tSegLen = regWrData[GRAN_W-1:0]; // [RULE6]
				`WSC_REG_TLOOP: next_s.tLoop = regWrData; // [RULE22]
				`WSC_REG_TFLAGS: next_s.tFlags = regWrData[4:0];
				default: ;
			endcase
		end
		// start conditions by trigger and arm mode
		unique case (s.trigMode)
			WSC_TRIG_TRIG: startOk = trigRise; // [RULE9]
			WSC_TRIG_GATE: startOk = trigRise; // [RULE11]
			default: startOk = 1'b1; // [RULE8]
		endcase
		if (s.armed && s.trigMode != WSC_TRIG_CONT) begin
			startOk = startOk && enableIn; // [RULE15]
		end
		// triggers outside the wait state are simply not looked at
		if (s.state != WSC_ST_WAIT) begin
			startOk = 1'b0; // [RULE10]
		end
		if (!s.run) begin
			next_s.state = WSC_ST_IDLE; // [RULE23]
		end else begin
			unique case (s.state)
				WSC_ST_IDLE: begin
					next_s.idx = s.startPtr; // [RULE2]
					next_s.loopBeg = s.startPtr;
					next_s.gran = '0;
					next_s.segLoops = 32'h0000_0001;
					next_s.seqLoops = 32'h0000_0001;
					next_s.firstHold = s.armed && s.trigMode == WSC_TRIG_CONT; // [RULE14]
					next_s.enSeen = 1'b0;
					next_s.blockLoops = 32'h0000_0000;
					next_s.state = WSC_ST_WAIT;
				end
				WSC_ST_WAIT: begin
					if (startOk) begin
						next_s.state = WSC_ST_PLAY; // [RULE13]
					end
				end
				WSC_ST_PLAY: begin
					next_s.validOut = 1'b1; // [RULE5]
					next_s.addrOut = tabStart[s.idx] + MEM_AW'(s.gran);
					next_s.gran = s.gran + GRAN_W'(1);
					if (s.trigMode == WSC_TRIG_GATE && trigFall) begin
						next_s.state = WSC_ST_WAIT; // [RULE11]
						next_s.idx = s.startPtr;
						next_s.blockLoops = 32'h0000_0000;
						next_s.gran = '0;
						next_s.segLoops = 32'h0000_0001;
						next_s.seqLoops = 32'h0000_0001;
					end else if (segEnd) begin
						next_s.gran = '0;
						passEnd = 1'b1;
					end
				end
				WSC_ST_HOLD: begin
					next_s.holdOut = 1'b1;
					if (evPending) begin
						consume = 1'b1;
						if (curAdv == WSC_ADV_SINGLE && !allLoops) begin
							next_s.segLoops = s.segLoops + 32'h0000_0001; // [RULE20]
						end else begin
							canStart = 1'b1; // [RULE19]
						end
						next_s.state = WSC_ST_PLAY;
					end
				end
				WSC_ST_DONE: begin
					next_s.state = WSC_ST_IDLE; // [RULE9]
				end
				default: next_s.state = WSC_ST_IDLE;
			endcase
		end
		// an enable edge between pass ends is kept until the pass ends
		if (s.firstHold && enRise) begin
			next_s.enSeen = 1'b1; // [RULE14]
		end
		// end of one pass of the current entry
		if (passEnd) begin
			if (s.firstHold) begin
				if (enRise || s.enSeen) begin
					next_s.firstHold = 1'b0; // [RULE14]
					next_s.enSeen = 1'b0;
					canStart = 1'b1;
				end
			end else begin
				unique case (curAdv)
					WSC_ADV_AUTO: begin
						if (allLoops) begin
							canStart = 1'b1; // [RULE17]
						end else begin
							next_s.segLoops = s.segLoops + 32'h0000_0001;
						end
					end
					WSC_ADV_COND: begin
						if (evPending) begin
							consume = 1'b1;
							canStart = 1'b1; // [RULE18]
						end
					end
					WSC_ADV_REPEAT: begin
						if (allLoops) begin
							next_s.state = WSC_ST_HOLD; // [RULE19]
						end else begin
							next_s.segLoops = s.segLoops + 32'h0000_0001;
						end
					end
					WSC_ADV_SINGLE: begin
						next_s.state = WSC_ST_HOLD; // [RULE20]
					end
				endcase
			end
		end
		// move to the following entry
		if (canStart) begin
			next_s.segLoops = 32'h0000_0001;
			next_s.idx = s.idx + DEPTH_W'(1); // [RULE2]
			next_s.state = WSC_ST_PLAY;
			if (curFlags[`WSC_FLAG_LOOPBEG]) begin
				next_s.loopBeg = s.idx;
			end
			if (curFlags[`WSC_FLAG_LOOPEND] && s.blockLoops > 32'h0000_0001) begin
				next_s.idx = s.loopBeg; // [RULE3]
				next_s.blockLoops = s.blockLoops - 32'h0000_0001;
			end else if (curFlags[`WSC_FLAG_LOOPEND]) begin
				next_s.blockLoops = 32'h0000_0000;
			end
			if (curFlags[`WSC_FLAG_SEQEND]) begin
				next_s.idx = s.startPtr;
				next_s.seqLoops = s.seqLoops + 32'h0000_0001;
				if (s.trigMode == WSC_TRIG_TRIG && s.seqLoopCfg != 32'h0000_0000
						&& s.seqLoops >= s.seqLoopCfg) begin
					next_s.state = WSC_ST_DONE; // [RULE7] [RULE9]
				end
			end
		end
		if (curFlags[`WSC_FLAG_LOOPBEG] && s.blockLoops == 32'h0000_0000 && s.state == WSC_ST_PLAY) begin
			next_s.blockLoops = tabLoop[s.idx]; // [RULE3]
		end
		unique case (regAddr)
			`WSC_REG_CTRL: next_s.rdData = {26'h0, s.seqAdv, s.trigMode, s.armed, s.run};
			`WSC_REG_START: next_s.rdData = 32'(s.startPtr);
			`WSC_REG_SEQLOOP: next_s.rdData = s.seqLoopCfg;
			`WSC_REG_STATUS: next_s.rdData = {27'h0, evPending, 1'b0, s.state};
			`WSC_REG_POS: next_s.rdData = 32'(s.idx);
			default: next_s.rdData = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0; // [RULE23]
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge clk) begin
		if (regWrite && regAddr == `WSC_REG_TWRITE && !s.run) begin
			tabStart[s.tAddr] <= s.tSegStart; // [RULE1]
			tabLen[s.tAddr] <= s.tSegLen;
			tabLoop[s.tAddr] <= s.tLoop;
			tabFlags[s.tAddr] <= s.tFlags;
		end
	end

	assign regRdData = s.rdPend ? s.rdData : 32'h0000_0000;
	assign memAddr = s.addrOut;
	assign memValid = s.validOut;
	assign holdLast = s.holdOut;
endmodule : wsc_sequencer

/* File: testbench/wsc_src_model.sv */
// trigger, gate, enable and event sources facing the sequencer
module wsc_src_model (
	// clock
	input wire logic clk,
	// source levels
	output logic trigLvl,
	output logic enableLvl,
	output logic eventLvl
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		trigLvl = 1'b0;
		enableLvl = 1'b0;
		eventLvl = 1'b0;
	end
	task automatic pulse_trig();
		@(posedge clk);
		trigLvl <= 1'b1;
		@(posedge clk);
		trigLvl <= 1'b0;
	endtask : pulse_trig
	task automatic pulse_event();
		@(posedge clk);
		eventLvl <= 1'b1;
		@(posedge clk);
		eventLvl <= 1'b0;
	endtask : pulse_event
	// gate shares the trigger line
	task automatic set_gate(input logic v);
		@(posedge clk);
		trigLvl <= v;
	endtask : set_gate
	task automatic set_enable(input logic v);
		@(posedge clk);
		enableLvl <= v;
	endtask : set_enable
endmodule : wsc_src_model

/* File: testbench/wsc_sequencer_props.sv */
// port checker of the sequencer
`include "wsc_cfg.svh"
module wsc_sequencer_props #(
	parameter int DEPTH_W = 6,
	parameter int MEM_AW = 24,
	parameter int GRAN_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [`WSC_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdData,
	// sources and memory side
	input wire logic trigIn,
	input wire logic enableIn,
	input wire logic eventIn,
	input wire logic [MEM_AW-1:0] memAddr,
	input wire logic memValid,
	input wire logic holdLast
);
	import wsc_pkg::*;
	logic [5:0] ctrl;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (reset);
	// shadow of the control register
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= 6'h0;
		end else if (regWrite && regAddr == `WSC_REG_CTRL) begin
			ctrl <= regWrData[5:0];
		end
	end
	AST_RD_ZERO: assert property (!$past(regRead) |-> regRdData == 32'h0)
		else $error("read data without a read");
	AST_RD_UNMAPPED: assert property (
		$past(regRead) && $past(regAddr) > `WSC_REG_POS |-> regRdData == 32'h0)
		else $error("unmapped read not zero");
	AST_RESET_QUIET: assert property (
		$past(reset) |-> !memValid && !holdLast && memAddr == '0)
		else $error("outputs active after reset");
	AST_STOP_QUIET: assert property (
		regWrite && regAddr == `WSC_REG_CTRL && !regWrData[0] |-> ##[1:3] !memValid && !holdLast)
		else $error("playback goes on after stop");
	AST_STATUS_IDLE: assert property (
		$past(regRead) && $past(regAddr) == `WSC_REG_STATUS && !$past(ctrl[0], 3) && !$past(ctrl[0])
		|-> regRdData[2:0] == WSC_ST_IDLE && !regRdData[4])
		else $error("status not idle in program mode");
	AST_HOLD_NO_PLAY: assert property (holdLast |-> !memValid)
		else $error("granule played while holding");
	AST_CONT_STARTS: assert property (
		!ctrl[0] && regWrite && regAddr == `WSC_REG_CTRL && regWrData[3:0] == 4'h1
		|-> ##[1:4] memValid)
		else $error("continuous run did not start");
	AST_TRIG_WAITS: assert property (
		(ctrl[0] && ctrl[3:2] == 2'h1 && !memValid && !trigIn)[*6] |=> !memValid)
		else $error("play started without trigger");
	AST_GATE_LOW_QUIET: assert property (
		(ctrl[0] && ctrl[3:2] == 2'h2 && !trigIn)[*8] |-> !memValid)
		else $error("play while gate low");
endmodule : wsc_sequencer_props
bind wsc_sequencer wsc_sequencer_props #(.DEPTH_W(DEPTH_W), .MEM_AW(MEM_AW), .GRAN_W(GRAN_W))
	wsc_sequencer_props_inst (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .trigIn(trigIn),
	.enableIn(enableIn), .eventIn(eventIn), .memAddr(memAddr), .memValid(memValid),
	.holdLast(holdLast));

/* File: testbench/waveform_sequencer_control_test.sv */
// self-checking bench of the waveform sequencer
`include "wsc_cfg.svh"
module waveform_sequencer_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import wsc_pkg::*;
	typedef struct {logic [1:0] m; logic h0; int a0; logic b0; logic b1; logic h1;} wsc_row_t;
	logic clk, reset, regWrite, regRead, memValid, holdLast, trigIn, enableIn, eventIn;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData, rd;
	logic [23:0] memAddr;
	int num_errors, n_checks, cAll, cA, cB;
	// mode, hold, first-element count (0 = open), second seen before and after event, hold
	wsc_row_t rows [4] = '{'{2'h0, 0, 0, 1, 1, 0}, '{2'h1, 0, 0, 0, 1, 0},
		'{2'h2, 1, 3, 0, 1, 1}, '{2'h3, 1, 1, 0, 0, 1}};
	////////////////////////////////
	wsc_sequencer wsc_sequencer_inst (.clk(clk), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.trigIn(trigIn), .enableIn(enableIn), .eventIn(eventIn), .memAddr(memAddr),
		.memValid(memValid), .holdLast(holdLast));
	wsc_src_model wsc_src_model_inst (.clk(clk), .trigLvl(trigIn), .enableLvl(enableIn),
		.eventLvl(eventIn));
	////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 rd = regRdData;
	endtask : rdreg
	task automatic ent(input logic [31:0] i, s, n, l, f);
		wr(`WSC_REG_TADDR, i);
		wr(`WSC_REG_TSEGSTART, s);
		wr(`WSC_REG_TSEGLEN, n);
		wr(`WSC_REG_TLOOP, l);
		wr(`WSC_REG_TFLAGS, f);
		wr(`WSC_REG_TWRITE, 32'h0);
	endtask : ent
	// counts granules played over n cycles
	task automatic watch(input int n);
		cAll = 0;
		cA = 0;
		cB = 0;
		repeat (n) begin
			@(negedge clk);
			cAll += memValid;
			cA += (memValid && memAddr == 24'h000200);
			cB += (memValid && memAddr == 24'h000300);
		end
	endtask : watch
	////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		regAddr = 8'h0;
		regWrData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk(memValid, 1'b0);
		chk(holdLast, 1'b0);
		wsc_src_model_inst.pulse_event();
		rdreg(`WSC_REG_STATUS);
		chk(rd & 32'h17, 32'h0);
		rdreg(`WSC_REG_CTRL);
		chk(rd, `WSC_CTRL_RESET);
		rdreg(8'h3c);
		chk(rd, 32'h0);
		ent(1, 32'h300, 1, 1, 32'h10);
		foreach (rows[k]) begin
			wr(`WSC_REG_CTRL, 32'h0);
			ent(0, 32'h200, 1, 3, {30'h0, rows[k].m});
			wr(`WSC_REG_CTRL, 32'h1);
			watch(30);
			chk(holdLast, rows[k].h0);
			chk(cB != 0, rows[k].b0);
			if (rows[k].a0 != 0) chk(cA, rows[k].a0);
			wsc_src_model_inst.pulse_event();
			watch(30);
			chk(cB != 0, rows[k].b1);
			chk(holdLast, rows[k].h1);
		end
		wr(`WSC_REG_CTRL, 32'h0);
		ent(0, 32'h200, 6, 1, 32'h0);
		ent(1, 32'h200, 1, 1, 32'h10);
		wr(`WSC_REG_SEQLOOP, 32'h1);
		wr(`WSC_REG_CTRL, 32'h5);
		watch(20);
		chk(cAll, 0);
		fork
			watch(30);
			begin
				wsc_src_model_inst.pulse_trig();
				repeat (3) @(posedge clk);
				wsc_src_model_inst.pulse_trig();
			end
		join
		chk(cAll, 7);
		chk(cA, 2);
		fork
			watch(30);
			wsc_src_model_inst.pulse_trig();
		join
		chk(cAll, 7);
		wr(`WSC_REG_CTRL, 32'h7);
		fork
			watch(20);
			wsc_src_model_inst.pulse_trig();
		join
		chk(cAll, 0);
		wsc_src_model_inst.set_enable(1'b1);
		fork
			watch(30);
			wsc_src_model_inst.pulse_trig();
		join
		chk(cAll, 7);
		wsc_src_model_inst.set_enable(1'b0);
		wr(`WSC_REG_CTRL, 32'h0);
		wr(`WSC_REG_SEQLOOP, 32'h0);
		wr(`WSC_REG_CTRL, 32'h9);
		watch(15);
		chk(cAll, 0);
		wsc_src_model_inst.set_gate(1'b1);
		watch(20);
		chk(cAll > 10, 1'b1);
		wsc_src_model_inst.set_gate(1'b0);
		repeat (8) @(posedge clk);
		watch(15);
		chk(cAll, 0);
		wsc_src_model_inst.set_gate(1'b1);
		watch(20);
		chk(cAll > 10, 1'b1);
		wsc_src_model_inst.set_gate(1'b0);
		wr(`WSC_REG_CTRL, 32'h0);
		ent(0, 32'h200, 1, 2, 32'h8);
		ent(1, 32'h300, 1, 1, 32'h4);
		ent(2, 32'h400, 1, 1, 32'h10);
		wr(`WSC_REG_SEQLOOP, 32'h1);
		wr(`WSC_REG_CTRL, 32'h5);
		fork
			watch(30);
			wsc_src_model_inst.pulse_trig();
		join
		chk(cAll, 7);
		chk(cB, 2);
		chk(cA, 4);
		wr(`WSC_REG_CTRL, 32'h0);
		ent(0, 32'h200, 3, 1, 32'h0);
		ent(1, 32'h300, 1, 1, 32'h10);
		wr(`WSC_REG_CTRL, 32'h3);
		watch(26);
		chk(cB, 0);
		chk(cA > 5, 1'b1);
		wsc_src_model_inst.set_enable(1'b1);
		watch(24);
		chk(cB > 3, 1'b1);
		wr(`WSC_REG_CTRL, 32'h0);
		wr(`WSC_REG_START, 32'h1);
		wr(`WSC_REG_CTRL, 32'h31);
		watch(12);
		chk(cA, 0);
		chk(cB > 5, 1'b1);
		rdreg(`WSC_REG_POS);
		chk(rd, 32'h1);
		rdreg(`WSC_REG_START);
		chk(rd, 32'h1);
		rdreg(`WSC_REG_CTRL);
		chk(rd, 32'h31);
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk(memValid, 1'b0);
		chk(holdLast, 1'b0);
		rdreg(`WSC_REG_START);
		chk(rd, 32'h0);
		give_verdict();
	end
endmodule : waveform_sequencer_control_test
